/* File: design/tw_control_port.sv */
// two-wire slave control port with the converter's control registers
module tw_control_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic busAddressSelectPins,
    input wire logic coastPolarityIn,
    input wire logic clampPulse,
    input wire logic pixelValid,
    input wire logic [7:0] redIn,
    input wire logic [7:0] greenIn,
    input wire logic [7:0] blueIn,
    output logic [7:0] redOut,
    output logic [7:0] greenOut,
    output logic [7:0] blueOut,
    output logic blueOe,
    output logic pllExtraDivide,
    output logic [1:0] greenEmbeddedSyncInputBw,
    output logic [1:0] sogFilterClass,
    output logic analogBandwidthLow,
    output logic [7:0] redTargetCode,
    output logic [7:0] greenTargetCode,
    output logic [7:0] blueTargetCode,
    output logic autoOffsetEnable,
    output logic autoOffsetHold,
    output logic [1:0] autoOffsetUpdateMode,
    output logic offsetUpdateTick
);
    tw_pkg::tw_regs_t q;
    tw_pkg::tw_regs_t d;
    logic startDet;
    logic stopDet;
    logic sclRise;
    logic sclFall;
    logic addrMatch;
    logic [7:0] rdByte;
    logic [5:0] lastCnt;

    function automatic logic [7:0] regRead(input logic [7:0] a,
                                           input tw_pkg::tw_regs_t s);
        logic [7:0] r;
        r = tw_pkg::UNMAPPED_READ;
        case (a)
            tw_pkg::OFS_STATUS: begin
                r[tw_pkg::BIT_COAST] = s.coastS;
            end
            tw_pkg::OFS_FORMAT: r = s.fmt;
            tw_pkg::OFS_PLL: r = s.pll;
            tw_pkg::OFS_TGT_RED: r = s.tgtRed;
            tw_pkg::OFS_TGT_GREEN: r = s.tgtGreen;
            tw_pkg::OFS_TGT_BLUE: r = s.tgtBlue;
            tw_pkg::OFS_AUTO: r = s.aoc;
            default: r = tw_pkg::UNMAPPED_READ;
        endcase
        return r;
    endfunction : regRead

    function automatic logic [5:0] updateLast(input logic [1:0] m);
        logic [5:0] r;
        case (m)
            tw_pkg::UPD_EVERY: r = tw_pkg::LAST_EVERY;
            tw_pkg::UPD_16: r = tw_pkg::LAST_16;
            default: r = tw_pkg::LAST_64;
        endcase
        return r;
    endfunction : updateLast

    function automatic logic [1:0] sogDecode(input logic [1:0] m);
        logic [1:0] r;
        case (m)
            2'h0: r = tw_pkg::SOG_300;
            2'h3: r = tw_pkg::SOG_6P5;
            default: r = tw_pkg::SOG_13;
        endcase
        return r;
    endfunction : sogDecode

    // edges judged on synchronised samples only
    assign startDet = q.sclS & q.sclPrev & q.sdaPrev & ~q.sdaS;
    assign stopDet = q.sclS & q.sclPrev & ~q.sdaPrev & q.sdaS;
    assign sclRise = q.sclS & ~q.sclPrev;
    assign sclFall = ~q.sclS & q.sclPrev;
    assign addrMatch = q.shift[7:1] == {tw_pkg::ADDR_UPPER, q.selS};
    assign rdByte = regRead(q.ptr, q);
    assign lastCnt = updateLast(q.aoc[tw_pkg::BIT_UPD_HI:tw_pkg::BIT_UPD_LO]);

    always_comb begin
        d = q;
        d.sclMeta = sclIn;
        d.sclS = q.sclMeta;
        d.sclPrev = q.sclS;
        d.sdaMeta = sdaIn;
        d.sdaS = q.sdaMeta;
        d.sdaPrev = q.sdaS;
        d.selMeta = busAddressSelectPins;
        d.selS = q.selMeta;
        d.coastMeta = coastPolarityIn;
        d.coastS = q.coastMeta;
        d.sdaOut = 1'b0;
        // a level change of data under high clock overrides any state
        if (startDet) begin
            d.st = tw_pkg::TW_RXADDR;
            d.bitCnt = 3'h0;
            d.byteDone = 1'b0;
            d.sdaOe = 1'b0;
        end else if (stopDet) begin
            d.st = tw_pkg::TW_IDLE;
            d.sdaOe = 1'b0;
            d.byteDone = 1'b0;
        end else begin
            case (q.st)
                tw_pkg::TW_RXADDR, tw_pkg::TW_RXBYTE: begin
                    if (sclRise) begin
                        d.shift = {q.shift[6:0], q.sdaS};
                        d.bitCnt = q.bitCnt + 3'h1;
                        d.byteDone = q.bitCnt == tw_pkg::BIT_LAST;
                    end else if (sclFall && q.byteDone) begin
                        d.byteDone = 1'b0;
                        if (q.st == tw_pkg::TW_RXADDR) begin
                            if (addrMatch) begin
                                d.rw = q.shift[0];
                                d.firstByte = 1'b1;
                                d.sdaOe = 1'b1;
                                d.st = tw_pkg::TW_ACKADDR;
                            end else begin
                                d.st = tw_pkg::TW_IGNORE;
                            end
                        end else begin
                            d.sdaOe = 1'b1;
                            d.st = tw_pkg::TW_ACKRX;
                            d.firstByte = 1'b0;
                            if (q.firstByte) begin
                                d.ptr = q.shift;
                            end else begin
                                d.ptr = q.ptr + 8'h01;
                                case (q.ptr)
                                    tw_pkg::OFS_FORMAT: d.fmt = q.shift;
                                    tw_pkg::OFS_PLL: d.pll = q.shift;
                                    tw_pkg::OFS_TGT_RED: d.tgtRed = q.shift;
                                    tw_pkg::OFS_TGT_GREEN:
                                        d.tgtGreen = q.shift;
                                    tw_pkg::OFS_TGT_BLUE: d.tgtBlue = q.shift;
                                    tw_pkg::OFS_AUTO: d.aoc = q.shift;
                                    default: d.aoc = q.aoc;
                                endcase
                            end
                        end
                    end
                end
                tw_pkg::TW_ACKADDR, tw_pkg::TW_ACKRX: begin
                    if (sclFall) begin
                        d.bitCnt = 3'h0;
                        if (q.rw) begin
                            d.st = tw_pkg::TW_TXBYTE;
                            d.shift = rdByte;
                            d.sdaOe = ~rdByte[7];
                        end else begin
                            d.st = tw_pkg::TW_RXBYTE;
                            d.sdaOe = 1'b0;
                        end
                    end
                end
                tw_pkg::TW_TXBYTE: begin
                    if (sclRise) begin
                        d.bitCnt = q.bitCnt + 3'h1;
                        d.byteDone = q.bitCnt == tw_pkg::BIT_LAST;
                    end else if (sclFall) begin
                        if (q.byteDone) begin
                            d.byteDone = 1'b0;
                            d.sdaOe = 1'b0;
                            d.st = tw_pkg::TW_ACKTX;
                            d.ptr = q.ptr + 8'h01;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.sdaOe = ~q.shift[6];
                        end
                    end
                end
                tw_pkg::TW_ACKTX: begin
                    // byteDone doubles as the master's acknowledge here
                    if (sclRise) begin
                        if (q.sdaS) begin
                            d.st = tw_pkg::TW_IGNORE;
                        end else begin
                            d.byteDone = 1'b1;
                        end
                    end else if (sclFall && q.byteDone) begin
                        d.byteDone = 1'b0;
                        d.bitCnt = 3'h0;
                        d.st = tw_pkg::TW_TXBYTE;
                        d.shift = rdByte;
                        d.sdaOe = ~rdByte[7];
                    end
                end
                tw_pkg::TW_IDLE, tw_pkg::TW_IGNORE: begin
                    d.sdaOe = 1'b0;
                end
                default: begin
                    d.st = tw_pkg::TW_IDLE;
                    d.sdaOe = 1'b0;
                end
            endcase
        end
        d.sogClass = sogDecode(q.pll[tw_pkg::BIT_SOG_HI:tw_pkg::BIT_SOG_LO]);
        // hold keeps the count too, so release resumes the same cadence
        d.tick = 1'b0;
        if (clampPulse && q.aoc[tw_pkg::BIT_AUTO_EN] &&
            !q.aoc[tw_pkg::BIT_AUTO_HOLD]) begin
            if (q.clampCnt >= lastCnt) begin
                d.clampCnt = 6'h00;
                d.tick = 1'b1;
            end else begin
                d.clampCnt = q.clampCnt + 6'h01;
            end
        end
        // blue release follows the mode at once, not the next pixel
        d.blueOe = q.fmt[tw_pkg::BIT_MODE444];
        if (pixelValid) begin
            d.greenOut = greenIn;
            if (q.fmt[tw_pkg::BIT_MODE444]) begin
                d.redOut = redIn;
                d.blueOut = blueIn;
                d.uvPhase = 1'b0;
            end else begin
                d.redOut = q.uvPhase ? redIn : blueIn;
                d.uvPhase = ~q.uvPhase;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= tw_pkg::TW_IDLE;
            q.sclMeta <= 1'b1;
            q.sclS <= 1'b1;
            q.sclPrev <= 1'b1;
            q.sdaMeta <= 1'b1;
            q.sdaS <= 1'b1;
            q.sdaPrev <= 1'b1;
            q.fmt <= tw_pkg::RST_FORMAT;
            q.pll <= tw_pkg::RST_PLL;
            q.tgtRed <= tw_pkg::RST_TARGET;
            q.tgtGreen <= tw_pkg::RST_TARGET;
            q.tgtBlue <= tw_pkg::RST_TARGET;
            q.aoc <= tw_pkg::RST_AUTO;
            q.blueOe <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sdaOut = q.sdaOut;
    assign sdaOe = q.sdaOe;
    assign redOut = q.redOut;
    assign greenOut = q.greenOut;
    assign blueOut = q.blueOut;
    assign blueOe = q.blueOe;
    assign pllExtraDivide = q.pll[tw_pkg::BIT_EXTRA_DIV];
    assign greenEmbeddedSyncInputBw =
        q.pll[tw_pkg::BIT_SOG_HI:tw_pkg::BIT_SOG_LO];
    assign sogFilterClass = q.sogClass;
    assign analogBandwidthLow = q.pll[tw_pkg::BIT_ANALOG_BW];
    assign redTargetCode = q.tgtRed;
    assign greenTargetCode = q.tgtGreen;
    assign blueTargetCode = q.tgtBlue;
    assign autoOffsetEnable = q.aoc[tw_pkg::BIT_AUTO_EN];
    assign autoOffsetHold = q.aoc[tw_pkg::BIT_AUTO_HOLD];
    assign autoOffsetUpdateMode = q.aoc[tw_pkg::BIT_UPD_HI:tw_pkg::BIT_UPD_LO];
    assign offsetUpdateTick = q.tick;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_START_ADDR: assert property (
        startDet |=> q.st == tw_pkg::TW_RXADDR && !q.sdaOe)
        else $error("start not followed by address phase");
    AST_STOP_IDLE: assert property (
        stopDet && !startDet |=> q.st == tw_pkg::TW_IDLE && !q.sdaOe)
        else $error("stop did not return to idle");
    AST_ADDR_ACK: assert property (
        q.st == tw_pkg::TW_RXADDR && sclFall && q.byteDone && addrMatch
        && !startDet && !stopDet
        |=> q.sdaOe && q.st == tw_pkg::TW_ACKADDR)
        else $error("matching address not acknowledged");
    AST_ADDR_MISS: assert property (
        q.st == tw_pkg::TW_RXADDR && sclFall && q.byteDone && !addrMatch
        && !startDet && !stopDet
        |=> q.st == tw_pkg::TW_IGNORE ##1 !q.sdaOe)
        else $error("mismatched address not ignored");
    AST_WR_INC: assert property (
        q.st == tw_pkg::TW_RXBYTE && sclFall && q.byteDone && !q.firstByte
        && !startDet && !stopDet
        |=> q.ptr == $past(q.ptr) + 8'h01)
        else $error("write pointer did not step by one");
    AST_TX_MSB: assert property (
        q.st == tw_pkg::TW_ACKADDR && sclFall && q.rw
        && !startDet && !stopDet
        |=> q.st == tw_pkg::TW_TXBYTE && q.sdaOe == !q.shift[7])
        else $error("read byte did not start with its top bit");
    AST_READ_NACK: assert property (
        q.st == tw_pkg::TW_ACKTX && sclRise && q.sdaS
        && !startDet && !stopDet
        |=> q.st == tw_pkg::TW_IGNORE && !q.sdaOe)
        else $error("master nack did not end the read");
    AST_STATUS_BIT: assert property (
        regRead(tw_pkg::OFS_STATUS, q) == {7'h00, q.coastS})
        else $error("status byte does not mirror coast polarity");
    AST_BLUE_REL: assert property (
        pixelValid && !q.fmt[tw_pkg::BIT_MODE444] |=> !blueOe)
        else $error("blue port driven in packed mode");
    AST_TICK_GATE: assert property (
        offsetUpdateTick |-> $past(clampPulse) && $past(autoOffsetEnable)
        && !$past(autoOffsetHold))
        else $error("update tick while disabled or held");
    AST_TICK_64: assert property (
        offsetUpdateTick && $past(autoOffsetUpdateMode[1])
        |-> $past(q.clampCnt) == tw_pkg::LAST_64)
        else $error("slow update mode ticked at wrong count");

    COV_WRITE: cover property (
        q.st == tw_pkg::TW_ACKRX && !q.firstByte ##[1:200] stopDet);
    COV_READ: cover property (
        q.st == tw_pkg::TW_TXBYTE ##[1:400] q.st == tw_pkg::TW_ACKTX);
    COV_RESTART: cover property (
        q.st == tw_pkg::TW_ACKRX ##[1:400] startDet);
    COV_NACK: cover property (q.st == tw_pkg::TW_ACKTX && sclRise && q.sdaS);
endmodule : tw_control_port

/* File: design/tw_pkg.sv */
// constants, types and state layout for the two-wire control port
// Functional notes
// - start: data falls while clock high, from idle with both lines high
// - stop: data rises while clock high; ends every sequence, back to idle
// - data changes only while clock low; high-clock change is start or stop
// - first byte: seven address bits then direction, 1 read, 0 write
// - address upper six bits fixed, lowest bit from the select pin
// - match: pull data low on ninth pulse; mismatch: release, ignore rest
// - every byte travels most significant bit first
// - without acknowledge on a write, data line stays released high
// - master not acknowledging a read byte ends data; slave releases line
// - first byte after address in a write is the register pointer
// - first data byte to pointer, pointer increments per further byte
// - read starts at the pointer, pointer increments after each byte
// - repeated start accepted; address and direction decoded again
// - status bit 0 shows coast polarity, 0 negative, 1 positive
// - mode bit 0 packs 4:2:2 on red and green, blue released
// - pll bit 7 set adds an extra divide-by-two to feedback
// - green sync filter: 00 300 MHz, 01/10 13 MHz, 11 6.5 MHz
// - colour input bandwidth bit: 0 300 MHz, 1 7 MHz
// - per colour target code, reset 4, aim of auto offset loop
// - auto offset bit 7 enables, bit 6 holds; both reset to 0
// - update mode: 00 every clamp, 01 every 16, 10 every 64; reset 10
package tw_pkg;
    localparam logic [5:0] ADDR_UPPER = 6'h26;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_FORMAT = 8'h15;
    localparam logic [7:0] OFS_PLL = 8'h16;
    localparam logic [7:0] OFS_TGT_RED = 8'h19;
    localparam logic [7:0] OFS_TGT_GREEN = 8'h1a;
    localparam logic [7:0] OFS_TGT_BLUE = 8'h1b;
    localparam logic [7:0] OFS_AUTO = 8'h1d;
    localparam logic [7:0] RST_FORMAT = 8'h02;
    localparam logic [7:0] RST_PLL = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h04;
    localparam logic [7:0] RST_AUTO = 8'h02;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int BIT_COAST = 0;
    localparam int BIT_MODE444 = 1;
    localparam int BIT_EXTRA_DIV = 7;
    localparam int BIT_SOG_HI = 6;
    localparam int BIT_SOG_LO = 5;
    localparam int BIT_ANALOG_BW = 4;
    localparam int BIT_AUTO_EN = 7;
    localparam int BIT_AUTO_HOLD = 6;
    localparam int BIT_UPD_HI = 1;
    localparam int BIT_UPD_LO = 0;
    localparam logic [1:0] UPD_EVERY = 2'h0;
    localparam logic [1:0] UPD_16 = 2'h1;
    localparam logic [5:0] LAST_EVERY = 6'h00;
    localparam logic [5:0] LAST_16 = 6'h0f;
    localparam logic [5:0] LAST_64 = 6'h3f;
    localparam logic [1:0] SOG_300 = 2'h0;
    localparam logic [1:0] SOG_13 = 2'h1;
    localparam logic [1:0] SOG_6P5 = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        TW_IDLE, TW_RXADDR, TW_ACKADDR, TW_RXBYTE, TW_ACKRX,
        TW_TXBYTE, TW_ACKTX, TW_IGNORE
    } tw_state_t;

    typedef struct packed {
        tw_state_t st;
        logic [2:0] bitCnt;
        logic byteDone;
        logic [7:0] shift;
        logic rw;
        logic firstByte;
        logic [7:0] ptr;
        logic sdaOe;
        logic sdaOut;
        logic sclMeta;
        logic sclS;
        logic sclPrev;
        logic sdaMeta;
        logic sdaS;
        logic sdaPrev;
        logic selMeta;
        logic selS;
        logic coastMeta;
        logic coastS;
        logic [7:0] fmt;
        logic [7:0] pll;
        logic [7:0] tgtRed;
        logic [7:0] tgtGreen;
        logic [7:0] tgtBlue;
        logic [7:0] aoc;
        logic [1:0] sogClass;
        logic [5:0] clampCnt;
        logic tick;
        logic uvPhase;
        logic [7:0] redOut;
        logic [7:0] greenOut;
        logic [7:0] blueOut;
        logic blueOe;
    } tw_regs_t;
endpackage : tw_pkg

/* File: tb/tw_bus_master.sv */
// bus master model that drives the serial clock and data toward the port
module tw_bus_master #(
    parameter int HALF = 10
) (
    input wire logic clk,
    input wire logic sdaLine,
    output logic sclLine,
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitClk

    // data moves 4 clocks after the fall, clear of the synchronisers
    task automatic clockBit(input logic drive, output logic seen);
        sdaPull = !drive;
        waitClk(HALF);
        sclLine = 1'b1;
        waitClk(HALF);
        seen = sdaLine;
        sclLine = 1'b0;
        waitClk(4);
    endtask : clockBit

    task automatic startCond();
        sdaPull = 1'b0;
        waitClk(HALF);
        sclLine = 1'b1;
        waitClk(HALF);
        sdaPull = 1'b1;
        waitClk(HALF);
        sclLine = 1'b0;
        waitClk(4);
    endtask : startCond

    task automatic stopCond();
        sdaPull = 1'b1;
        waitClk(HALF);
        sclLine = 1'b1;
        waitClk(HALF);
        sdaPull = 1'b0;
        waitClk(HALF);
    endtask : stopCond

    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(d[i], s);
        end
        clockBit(1'b1, s);
        ack = !s;
    endtask : writeByte

    task automatic readByte(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(1'b1, d[i]);
        end
        clockBit(!ackIt, s);
    endtask : readByte
endmodule : tw_bus_master

/* File: tb/testbench.sv */
// self-checking bench for the two-wire control port
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic busAddressSelectPins = 1'b0;
    logic coastPolarityIn = 1'b1;
    logic clampPulse = 1'b0;
    logic pixelValid = 1'b0;
    logic [7:0] redIn = 8'h00, greenIn = 8'h00, blueIn = 8'h00;
    logic sclIn, sdaIn, sdaPull, sdaOut, sdaOe;
    logic [7:0] redOut, greenOut, blueOut;
    logic [7:0] redTargetCode, greenTargetCode, blueTargetCode;
    logic blueOe, pllExtraDivide, analogBandwidthLow;
    logic autoOffsetEnable, autoOffsetHold, offsetUpdateTick;
    logic [1:0] greenEmbeddedSyncInputBw, sogFilterClass;
    logic [1:0] autoOffsetUpdateMode;
    logic [7:0] wBuf [4];
    logic [7:0] eBuf [10];
    logic [7:0] rBuf [10];
    int miscompares = 0;
    int checked = 0;

    always #50 clk = ~clk;
    // open drain with pull-up: released line reads high
    assign sdaIn = !(sdaPull || (sdaOe && !sdaOut));

    tw_control_port u_dut (.clk, .resetn, .sclIn, .sdaIn, .sdaOut, .sdaOe,
        .busAddressSelectPins, .coastPolarityIn, .clampPulse, .pixelValid,
        .redIn, .greenIn, .blueIn, .redOut, .greenOut, .blueOut, .blueOe,
        .pllExtraDivide, .greenEmbeddedSyncInputBw, .sogFilterClass,
        .analogBandwidthLow, .redTargetCode, .greenTargetCode,
        .blueTargetCode, .autoOffsetEnable, .autoOffsetHold,
        .autoOffsetUpdateMode, .offsetUpdateTick);

    tw_bus_master u_master (.clk(clk), .sdaLine(sdaIn), .sclLine(sclIn),
        .sdaPull(sdaPull));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic writeRegs(input logic [7:0] ptr, input int n);
        logic ack;
        u_master.startCond();
        u_master.writeByte({tw_pkg::ADDR_UPPER, busAddressSelectPins, 1'b0},
            ack);
        check(8'(ack), 8'h01);
        u_master.writeByte(ptr, ack);
        for (int i = 0; i < n; i++) begin
            u_master.writeByte(wBuf[i], ack);
            check(8'(ack), 8'h01);
        end
        u_master.stopCond();
    endtask : writeRegs

    // pointer set by a write, then a repeated start turns to reading
    task automatic readRegs(input logic [7:0] ptr, input int n);
        logic ack;
        logic s;
        u_master.startCond();
        u_master.writeByte({tw_pkg::ADDR_UPPER, busAddressSelectPins, 1'b0},
            ack);
        u_master.writeByte(ptr, ack);
        check(8'(ack), 8'h01);
        u_master.startCond();
        u_master.writeByte({tw_pkg::ADDR_UPPER, busAddressSelectPins, 1'b1},
            ack);
        check(8'(ack), 8'h01);
        for (int i = 0; i < n; i++) begin
            u_master.readByte(i != n - 1, rBuf[i]);
            check(rBuf[i], eBuf[i]);
        end
        u_master.clockBit(1'b1, s);
        check(8'(s), 8'h01);
        u_master.stopCond();
    endtask : readRegs

    task automatic testResetValues();
        eBuf = '{8'h01, tw_pkg::RST_FORMAT, tw_pkg::RST_PLL,
            tw_pkg::UNMAPPED_READ, tw_pkg::UNMAPPED_READ, tw_pkg::RST_TARGET,
            tw_pkg::RST_TARGET, tw_pkg::RST_TARGET, tw_pkg::UNMAPPED_READ,
            tw_pkg::RST_AUTO};
        readRegs(tw_pkg::OFS_STATUS, 10);
        check(8'(autoOffsetUpdateMode), 8'h02);
        check(8'({autoOffsetEnable, autoOffsetHold}), 8'h00);
        check(blueTargetCode, 8'h04);
    endtask : testResetValues

    task automatic testFields();
        logic [1:0] sogExp [4] = '{tw_pkg::SOG_300, tw_pkg::SOG_13,
            tw_pkg::SOG_13, tw_pkg::SOG_6P5};
        coastPolarityIn = 1'b0;
        wBuf = '{8'hff, 8'h00, 8'hb0, 8'h00};
        writeRegs(tw_pkg::OFS_STATUS, 3);
        check(8'(pllExtraDivide), 8'h01);
        check(8'(greenEmbeddedSyncInputBw), 8'h01);
        check(8'(analogBandwidthLow), 8'h01);
        check(8'(blueOe), 8'h00);
        eBuf[0:2] = '{8'h00, 8'h00, 8'hb0};
        readRegs(tw_pkg::OFS_STATUS, 3);
        for (int c = 0; c < 4; c++) begin
            wBuf[0] = {1'b0, 2'(c), 5'h00};
            writeRegs(tw_pkg::OFS_PLL, 1);
            check(8'(sogFilterClass), 8'(sogExp[c]));
        end
        check(8'(pllExtraDivide), 8'h00);
        check(8'(analogBandwidthLow), 8'h00);
        wBuf = '{8'h11, 8'h22, 8'h33, 8'h00};
        writeRegs(tw_pkg::OFS_TGT_RED, 3);
        check(8'(greenTargetCode), 8'h22);
        check(8'(blueTargetCode), 8'h33);
    endtask : testFields

    task automatic testAddress();
        logic ack;
        u_master.startCond();
        u_master.writeByte({tw_pkg::ADDR_UPPER, !busAddressSelectPins, 1'b0},
            ack);
        check(8'(ack), 8'h00);
        u_master.writeByte(tw_pkg::OFS_TGT_RED, ack);
        u_master.writeByte(8'h5a, ack);
        check(8'(ack), 8'h00);
        u_master.stopCond();
        check(redTargetCode, 8'h11);
        busAddressSelectPins = 1'b1;
        wBuf = '{8'h77, 8'h00, 8'h00, 8'h00};
        writeRegs(tw_pkg::OFS_TGT_RED, 1);
        check(redTargetCode, 8'h77);
        busAddressSelectPins = 1'b0;
    endtask : testAddress

    task automatic pixel(input logic [7:0] r, input logic [7:0] b);
        @(posedge clk);
        #1;
        redIn = r;
        greenIn = r ^ b;
        blueIn = b;
        pixelValid = 1'b1;
        @(posedge clk);
        #1;
        pixelValid = 1'b0;
    endtask : pixel

    // 4:2:2 is still selected from the field test
    task automatic testPixels();
        for (int i = 0; i < 4; i++) begin
            pixel(8'h10 + 8'(i), 8'h30 + 8'(i));
            check(redOut, (i % 2) ? redIn : blueIn);
            check(greenOut, redIn ^ blueIn);
        end
        wBuf[0] = 8'h02;
        writeRegs(tw_pkg::OFS_FORMAT, 1);
        check(8'(blueOe), 8'h01);
        pixel(8'hc3, 8'h5e);
        check(redOut, 8'hc3);
        check(blueOut, 8'h5e);
    endtask : testPixels

    task automatic clampOnce(output logic t);
        @(posedge clk);
        #1;
        clampPulse = 1'b1;
        @(posedge clk);
        #1;
        clampPulse = 1'b0;
        t = offsetUpdateTick;
    endtask : clampOnce

    task automatic testTick();
        int period [4] = '{1, 16, 64, 64};
        logic t;
        for (int m = 0; m < 4; m++) begin
            wBuf[0] = 8'h80 | 8'(m);
            writeRegs(tw_pkg::OFS_AUTO, 1);
            check(8'(autoOffsetUpdateMode), 8'(m));
            for (int i = 1; i <= period[m]; i++) begin
                clampOnce(t);
                check(8'(t), 8'(i == period[m]));
            end
        end
        for (int k = 0; k < 2; k++) begin
            wBuf[0] = k ? 8'h00 : 8'hc0;
            writeRegs(tw_pkg::OFS_AUTO, 1);
            check(8'(autoOffsetHold), 8'(k == 0));
            clampOnce(t);
            check(8'(t), 8'h00);
        end
    endtask : testTick

    // generous: the whole sequence needs under a fifth of this
    initial begin
        #(90000 * 100);
        miscompares++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        testResetValues();
        testFields();
        testAddress();
        testPixels();
        testTick();
        test_done();
    end
endmodule : testbench
